// file: core/dsr_readout.sv
// status word readout and feedback sampling strobe of a five channel switch
// assumes the serial engine pulses so_read_in per word and pwm/fault inputs are synchronous
`timescale 1ns/1ps
// How it works
// - every word carries fail operation bit
// - summary flags in quick, channel and device words, clear after reads
// - device summary ORs six device flags
// - overload summary ORs overcurrent and shutdown
// - quick flag ORs channel fault bits
// - address zero returns quick status word
// - channel word field layout fixed
// - newest overcurrent code overwrites unread one
// - overcurrent code encoding table
// - io word reports live levels
// - output levels undefined during undervoltage
// - part code reads zero in undervoltage
// - feedback only in normal mode
// - current feedback gated by window, pwm
// - offset polarity flips on strobe rise
// - offset cancel enable, forced off in fail
// - two-bit strobe setting selects behaviour
// - strobe suppressed in window, off, fault
// - blank strobe after mux or polarity change
// - clock failure gives 6.5 ms square
// - full duty gives overflow high pulse
// - voltage feedback gives clock/1024 square
// - address persistence bit controls reverting
// - channel diagnoses released by its read
module dsr_readout #(
  parameter int unsigned FAILSAFE_HALF = dsr_pkg::FAILSAFE_CYC / 2
) (
  // clock and reset
  input  wire logic                    clk_sys_in,
  input  wire logic                    rst_b_in,
  // serial readout port
  input  wire logic                    addr_wr_in,
  input  wire logic [3:0]              readout_address_in,
  input  wire logic                    readout_address_persistence_in,
  input  wire logic                    so_read_in,
  output logic [15:0]                  so_word_out,
  output logic                         so_valid_out,
  // operating mode
  input  wire logic                    fail_operation_flag_in,
  input  wire logic                    normal_mode_in,
  // channel fault events
  input  wire logic [dsr_pkg::NCH-1:0] ots_evt_in,
  input  wire logic [dsr_pkg::NCH-1:0] otw_evt_in,
  input  wire logic [dsr_pkg::NCH-1:0] oc_evt_in,
  input  wire logic [3*dsr_pkg::NCH-1:0] oc_code_in,
  input  wire logic [dsr_pkg::NCH-1:0] olon_evt_in,
  input  wire logic [dsr_pkg::NCH-1:0] oloff_evt_in,
  // device fault events
  input  wire logic                    regs_cleared_evt_in,
  input  wire logic                    undervoltage_evt_in,
  input  wire logic                    overvoltage_evt_in,
  input  wire logic                    charge_pump_fault_evt_in,
  input  wire logic                    clock_failure_evt_in,
  input  wire logic                    test_activation_evt_in,
  input  wire logic                    serial_failure_evt_in,
  // live levels
  input  wire logic                    limp_input_level_in,
  input  wire logic [3:0]              control_input_level_in,
  input  wire logic [3:0]              input_toggle_in,
  input  wire logic [dsr_pkg::NCH-1:0] output_level_bit_in,
  // feedback control
  input  wire logic [2:0]              feedback_select_in,
  input  wire logic                    strobe_setting_low_in,
  input  wire logic                    strobe_setting_high_in,
  input  wire logic [dsr_pkg::NCH-1:0] offset_cancel_enable_in,
  input  wire logic [dsr_pkg::NCH-1:0] pwm_on_in,
  input  wire logic [dsr_pkg::NCH-1:0] pwm_full_in,
  input  wire logic                    pwm_cycle_start_in,
  input  wire logic                    pwm_overflow_in,
  input  wire logic                    pwm_clock_fail_in,
  input  wire logic [dsr_pkg::NCH-1:0] high_current_window_in,
  input  wire logic [dsr_pkg::NCH-1:0] output_fault_in,
  // feedback outputs
  output logic                         feedback_enable_out,
  output logic [2:0]                   feedback_select_out,
  output logic                         current_feedback_gate_out,
  output logic [dsr_pkg::NCH-1:0]      offset_cancel_sense_mode_out,
  output logic                         offset_polarity_out,
  output logic                         feedback_sample_strobe_drv_out,
  output logic                         feedback_sample_strobe_oe_out
);
  import dsr_pkg::*;

  logic [6:0]     chan_flags [NCH];
  logic [NCH-1:0] chan_clr, quick_w;
  logic [3:0]     addr_r;
  logic           persist_r;
  logic           rcf_r, uvf_r, ovf_r, cpf_r, clock_failure_flag_r, tmf_r, serial_failure_flag_r;
  logic           dsf_w, ovl_w, olf_w, dev_clr;
  logic [15:0]    so_word_r, word_nxt;
  logic           so_valid_r;

  // ---------------- status latches ----------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      dsr_chan_latch u_latch (
        .clk_sys_in   (clk_sys_in),
        .rst_b_in     (rst_b_in),
        .ots_evt_in   (ots_evt_in[g]),
        .otw_evt_in   (otw_evt_in[g]),
        .oc_evt_in    (oc_evt_in[g]),
        .oc_code_in   (oc_code_in[3*g +: 3]),
        .olon_evt_in  (olon_evt_in[g]),
        .oloff_evt_in (oloff_evt_in[g]),
        .clr_in       (chan_clr[g]),
        .flags_out    (chan_flags[g])
      );
      assign chan_clr[g] = so_read_in && addr_r == ADDR_CH1 + 4'(g);
      assign quick_w[g]  = |chan_flags[g];
    end
  endgenerate

  assign dev_clr = so_read_in && addr_r == ADDR_DEV;

  // device flags are sticky; a new event wins over the clearing read
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rcf_r  <= 1'b0;
      uvf_r  <= 1'b0;
      ovf_r  <= 1'b0;
      cpf_r  <= 1'b0;
      clock_failure_flag_r <= 1'b0;
      tmf_r  <= 1'b0;
      serial_failure_flag_r <= 1'b0;
    end else begin
      rcf_r  <= regs_cleared_evt_in      | (rcf_r  & ~dev_clr);
      uvf_r  <= undervoltage_evt_in      | (uvf_r  & ~dev_clr);
      ovf_r  <= overvoltage_evt_in       | (ovf_r  & ~dev_clr);
      cpf_r  <= charge_pump_fault_evt_in | (cpf_r  & ~dev_clr);
      clock_failure_flag_r <= clock_failure_evt_in     | (clock_failure_flag_r & ~dev_clr);
      tmf_r  <= test_activation_evt_in   | (tmf_r  & ~dev_clr);
      serial_failure_flag_r <= serial_failure_evt_in    | (serial_failure_flag_r & ~dev_clr);
    end
  end

  // summaries follow the latches, so they drop only once all are read
  always_comb begin
    ovl_w = 1'b0;
    olf_w = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      ovl_w = ovl_w | chan_flags[i][F_OTS] | (chan_flags[i][F_OC_LSB +: 3] != OC_NONE);
      olf_w = olf_w | chan_flags[i][F_OLON] | chan_flags[i][F_OLOFF];
    end
  end
  assign dsf_w = rcf_r | uvf_r | ovf_r | cpf_r | clock_failure_flag_r | tmf_r;

  // ---------------- word assembly ----------------
  always_comb begin
    word_nxt = '0;
    word_nxt[FM_BIT] = fail_operation_flag_in;
    if (addr_r == ADDR_ALIAS || addr_r == ADDR_QUICK) begin
      word_nxt[ADDR_LSB +: 4] = ADDR_QUICK;
      word_nxt[DSF_BIT -: 3]  = {dsf_w, ovl_w, olf_w};
      word_nxt[7:0]           = {cpf_r, rcf_r, clock_failure_flag_r, quick_w};
    end else if (addr_r >= ADDR_CH1 && addr_r <= ADDR_CH5) begin
      word_nxt[ADDR_LSB +: 4] = addr_r;
      word_nxt[DSF_BIT -: 3]  = {dsf_w, ovl_w, olf_w};
      word_nxt[6:0]           = chan_flags[3'(addr_r - ADDR_CH1)];
    end else if (addr_r == ADDR_DEV) begin
      word_nxt[ADDR_LSB +: 4] = ADDR_DEV;
      word_nxt[DSF_BIT -: 3]  = {dsf_w, ovl_w, olf_w};
      word_nxt[4:0]           = {tmf_r, ovf_r, uvf_r, serial_failure_flag_r, limp_input_level_in};
    end else if (addr_r == ADDR_IO) begin
      word_nxt[ADDR_LSB +: 4] = ADDR_IO;
      word_nxt[OVL_BIT]       = |input_toggle_in;
      word_nxt[8:5]           = control_input_level_in;
      // undefined levels are shown as zero rather than left floating
      word_nxt[4:0]           = uvf_r ? '0 : output_level_bit_in;
    end else if (addr_r == ADDR_ID) begin
      word_nxt[ADDR_LSB +: 4] = ADDR_ID;
      word_nxt[7:0]           = uvf_r ? 8'h00 : PART_CODE;
    end else begin
      word_nxt[ADDR_LSB +: 4] = addr_r;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      so_word_r  <= '0;
      so_valid_r <= 1'b0;
    end else begin
      so_valid_r <= so_read_in;
      if (so_read_in) begin
        so_word_r <= word_nxt;
      end
    end
  end

  // a write and a read in one cycle: the write wins, the read used the old address
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_r    <= ADDR_QUICK;
      persist_r <= 1'b0;
    end else if (addr_wr_in) begin
      addr_r    <= readout_address_in;
      persist_r <= readout_address_persistence_in;
    end else if (so_read_in && !persist_r) begin
      addr_r    <= ADDR_QUICK;
    end
  end

  assign so_word_out  = so_word_r;
  assign so_valid_out = so_valid_r;

  // ---------------- feedback control ----------------
  logic           normal_w, is_cur, acm_sel, strobe_low_r, strobe_low_nxt;
  logic [2:0]     sel_prev_r;
  logic           fb_en_r, gate_r, pol_r, hold_r, on_prev_r;
  logic [NCH-1:0] acm_r;
  logic [DIV_W-1:0] div_r;
  logic [CNT_W-1:0] fs_cnt_r, blank_r, pulse_r;
  logic           fs_sq_r;
  logic [ON_W-1:0] on_cnt_r, last_len_r;
  dsr_stb_e       st_r;
  logic           mux_chg, pol_flip, sel_on, sel_rise;
  logic [1:0]     stb_set;

  assign normal_w = normal_mode_in & ~fail_operation_flag_in;
  assign is_cur   = feedback_select_in < SEL_TEMP;
  assign stb_set  = {strobe_setting_high_in, strobe_setting_low_in};
  assign sel_on   = is_cur && pwm_on_in[feedback_select_in];
  assign sel_rise = sel_on & ~on_prev_r;
  assign acm_sel  = is_cur && acm_r[feedback_select_in];
  assign mux_chg  = feedback_select_in != sel_prev_r;
  assign pol_flip = acm_sel & strobe_low_r & ~strobe_low_nxt;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fb_en_r <= 1'b0;
      gate_r  <= 1'b0;
      acm_r   <= '0;
    end else begin
      fb_en_r <= normal_w;
      gate_r  <= normal_w & sel_on & ~high_current_window_in[feedback_select_in];
      acm_r   <= fail_operation_flag_in ? '0 : offset_cancel_enable_in;
    end
  end

  // free running dividers for the voltage and clock-failure square waves
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_r    <= '0;
      fs_cnt_r <= '0;
      fs_sq_r  <= 1'b0;
    end else begin
      div_r <= div_r + 1'b1;
      if (fs_cnt_r == CNT_W'(FAILSAFE_HALF - 1)) begin
        fs_cnt_r <= '0;
        fs_sq_r  <= ~fs_sq_r;
      end else begin
        fs_cnt_r <= fs_cnt_r + 1'b1;
      end
    end
  end

  // on-pulse length for the half-pulse setting, fault hold and overflow pulse
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      on_prev_r  <= 1'b0;
      on_cnt_r   <= '0;
      last_len_r <= '0;
      hold_r     <= 1'b0;
      pulse_r    <= '0;
      sel_prev_r <= '0;
    end else begin
      on_prev_r  <= sel_on;
      sel_prev_r <= feedback_select_in;
      if (sel_on) begin
        on_cnt_r <= on_cnt_r + 1'b1;
      end else begin
        on_cnt_r <= '0;
      end
      if (on_prev_r && !sel_on) begin
        last_len_r <= on_cnt_r;
      end
      if (is_cur && output_fault_in[feedback_select_in]) begin
        hold_r <= 1'b1;
      end else if (sel_rise) begin
        hold_r <= 1'b0;
      end
      if (pwm_overflow_in) begin
        pulse_r <= CNT_W'(PULSE_CYC);
      end else if (pulse_r != '0) begin
        pulse_r <= pulse_r - 1'b1;
      end
    end
  end

  // blanking after mux or polarity change, then wait for next cycle if asked
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r    <= DSR_ST_RUN;
      blank_r <= '0;
    end else if (mux_chg || pol_flip) begin
      st_r    <= DSR_ST_BLANK;
      blank_r <= CNT_W'(BLANK_CYC - 1);
    end else begin
      case (st_r)
        DSR_ST_BLANK: begin
          if (blank_r == '0) begin
            st_r <= stb_set[1] ? DSR_ST_WAIT : DSR_ST_RUN;
          end else begin
            blank_r <= blank_r - 1'b1;
          end
        end
        DSR_ST_WAIT: begin
          if (pwm_cycle_start_in) begin
            st_r <= DSR_ST_RUN;
          end
        end
        default: st_r <= DSR_ST_RUN;
      endcase
    end
  end

  // strobe drive decision; low means active
  always_comb begin
    strobe_low_nxt = 1'b0;
    if (!normal_w) begin
      strobe_low_nxt = 1'b0;
    end else if (pwm_clock_fail_in) begin
      strobe_low_nxt = fs_sq_r;
    end else if (!is_cur) begin
      strobe_low_nxt = div_r[DIV_W-1];
    end else if (stb_set == STB_OFF) begin
      strobe_low_nxt = 1'b0;
    end else if (pwm_full_in[feedback_select_in] && stb_set[1]) begin
      strobe_low_nxt = (pulse_r == '0) & ~hold_r;
    end else if (st_r != DSR_ST_RUN || hold_r || high_current_window_in[feedback_select_in] || !sel_on) begin
      strobe_low_nxt = 1'b0;
    end else if (stb_set == STB_HALF) begin
      strobe_low_nxt = on_cnt_r >= (last_len_r >> 1);
    end else begin
      strobe_low_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strobe_low_r <= 1'b0;
      pol_r        <= 1'b0;
    end else begin
      strobe_low_r <= strobe_low_nxt;
      if (pol_flip) begin
        pol_r <= ~pol_r;
      end
    end
  end

  // open drain: the data flop only ever holds zero
  logic drv_r;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      drv_r <= 1'b0;
    end else begin
      drv_r <= 1'b0;
    end
  end

  assign feedback_enable_out            = fb_en_r;
  assign feedback_select_out            = sel_prev_r;
  assign current_feedback_gate_out      = gate_r;
  assign offset_cancel_sense_mode_out   = acm_r;
  assign offset_polarity_out            = pol_r;
  assign feedback_sample_strobe_drv_out = drv_r;
  assign feedback_sample_strobe_oe_out  = strobe_low_r;

  // ---------------- assertions ----------------
  property p_fm_bit;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    so_read_in |=> so_word_out[FM_BIT] == $past(fail_operation_flag_in);
  endproperty
  a_fm_bit: assert property (p_fm_bit) else $error("fail bit wrong in word");

  property p_summary;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    so_read_in && addr_r == ADDR_QUICK |=> so_word_out[OVL_BIT] == $past(ovl_w);
  endproperty
  a_summary: assert property (p_summary) else $error("overload summary wrong");

  property p_dsf_uv;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    undervoltage_evt_in |=> dsf_w && uvf_r;
  endproperty
  a_dsf_uv: assert property (p_dsf_uv) else $error("undervoltage missing from summary");

  property p_quick;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    ots_evt_in[0] |=> quick_w[0] && ovl_w;
  endproperty
  a_quick: assert property (p_quick) else $error("quick flag not set");

  property p_alias;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    so_read_in && addr_r == ADDR_ALIAS |=> so_word_out[ADDR_LSB +: 4] == ADDR_QUICK;
  endproperty
  a_alias: assert property (p_alias) else $error("address zero not quick word");

  property p_oc_over;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    oc_evt_in[0] |=> chan_flags[0][F_OC_LSB +: 3] == $past(oc_code_in[2:0]);
  endproperty
  a_oc_over: assert property (p_oc_over) else $error("overcurrent code not newest");

  property p_id_uv;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    so_read_in && addr_r == ADDR_ID && uvf_r |=> so_word_out[7:0] == 8'h00;
  endproperty
  a_id_uv: assert property (p_id_uv) else $error("part code shown in undervoltage");

  property p_revert;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    so_read_in && !addr_wr_in && !persist_r |=> addr_r == ADDR_QUICK;
  endproperty
  a_revert: assert property (p_revert) else $error("address did not revert");

  property p_no_fb;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    !normal_w |=> !feedback_sample_strobe_oe_out && !feedback_enable_out && !current_feedback_gate_out;
  endproperty
  a_no_fb: assert property (p_no_fb) else $error("feedback active outside normal mode");

  property p_pol;
    @(posedge clk_sys_in) disable iff (!rst_b_in)
    $fell(feedback_sample_strobe_oe_out) && $past(acm_sel) |-> pol_r != $past(pol_r);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity not flipped on strobe rise");
endmodule : dsr_readout

// file: include/dsr_pkg.sv
// constants for the diagnostic status readout and feedback strobe block
// assumes a 40 MHz system clock and five power channels
package dsr_pkg;
  localparam int unsigned NCH          = 5;
  localparam int unsigned CLK_HZ       = 40_000_000;
  // readout addresses; the top nibble of each word repeats its own address
  localparam logic [3:0]  ADDR_ALIAS   = 4'h0;
  localparam logic [3:0]  ADDR_QUICK   = 4'h1;
  localparam logic [3:0]  ADDR_CH1     = 4'h2;
  localparam logic [3:0]  ADDR_CH5     = 4'h6;
  localparam logic [3:0]  ADDR_DEV     = 4'h7;
  localparam logic [3:0]  ADDR_IO      = 4'h8;
  localparam logic [3:0]  ADDR_ID      = 4'h9;
  // field positions
  localparam int unsigned FM_BIT       = 11;
  localparam int unsigned DSF_BIT      = 10;
  localparam int unsigned OVL_BIT      = 9;
  localparam int unsigned ADDR_LSB     = 12;
  // channel flag vector layout inside a channel word (d6..d0)
  localparam int unsigned F_OTS        = 6;
  localparam int unsigned F_OTW        = 5;
  localparam int unsigned F_OC_LSB     = 2;
  localparam int unsigned F_OLON       = 1;
  localparam int unsigned F_OLOFF      = 0;
  // overcurrent codes
  localparam logic [2:0]  OC_NONE      = 3'h0;
  localparam logic [2:0]  OC_HI1       = 3'h1;
  localparam logic [2:0]  OC_HI2       = 3'h2;
  localparam logic [2:0]  OC_HI3       = 3'h3;
  localparam logic [2:0]  OC_LO        = 3'h4;
  localparam logic [2:0]  OC_HI_OD     = 3'h5;
  localparam logic [2:0]  OC_SEVERE    = 3'h6;
  // feedback selection: channels 0..4, then temperature and supply
  localparam logic [2:0]  SEL_TEMP     = 3'h5;
  localparam logic [2:0]  SEL_SUPPLY   = 3'h6;
  // strobe settings
  localparam logic [1:0]  STB_OFF      = 2'h0;
  localparam logic [1:0]  STB_VALID    = 2'h1;
  localparam logic [1:0]  STB_NEXT     = 2'h2;
  localparam logic [1:0]  STB_HALF     = 2'h3;
  // identification, arbitrary value
  localparam logic [7:0]  PART_CODE    = 8'h5a;
  // timing
  localparam int unsigned DIV_W        = 10;   // clock / 1024 square wave
  localparam int unsigned PULSE_US     = 100;
  localparam int unsigned PULSE_CYC    = PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BLANK_US     = 50;   // turn-on delay plus settling
  localparam int unsigned BLANK_CYC    = BLANK_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FAILSAFE_US  = 6500;
  localparam int unsigned FAILSAFE_CYC = FAILSAFE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W        = 18;
  localparam int unsigned ON_W         = 20;

  typedef enum logic [1:0] {
    DSR_ST_RUN   = 2'b00,
    DSR_ST_BLANK = 2'b01,
    DSR_ST_WAIT  = 2'b10
  } dsr_stb_e;
endpackage : dsr_pkg

// file: core/dsr_chan_latch.sv
// one channel's latched fault flags, cleared by a read of its status word
// assumes event inputs are single-cycle pulses synchronous to clk_sys_in
`timescale 1ns/1ps
module dsr_chan_latch (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_b_in,
  // fault events
  input  wire logic       ots_evt_in,
  input  wire logic       otw_evt_in,
  input  wire logic       oc_evt_in,
  input  wire logic [2:0] oc_code_in,
  input  wire logic       olon_evt_in,
  input  wire logic       oloff_evt_in,
  // clear on read
  input  wire logic       clr_in,
  // latched flags, d6..d0 layout
  output logic [6:0]      flags_out
);
  import dsr_pkg::*;
  logic       ots_r, otw_r, olon_r, oloff_r;
  logic [2:0] oc_r;

  // set beats clear so a fault during the read is kept
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ots_r   <= 1'b0;
      otw_r   <= 1'b0;
      olon_r  <= 1'b0;
      oloff_r <= 1'b0;
    end else begin
      ots_r   <= ots_evt_in   | (ots_r   & ~clr_in);
      otw_r   <= otw_evt_in   | (otw_r   & ~clr_in);
      olon_r  <= olon_evt_in  | (olon_r  & ~clr_in);
      oloff_r <= oloff_evt_in | (oloff_r & ~clr_in);
    end
  end

  // newest overcurrent code overwrites an unread one
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      oc_r <= OC_NONE;
    end else if (oc_evt_in) begin
      oc_r <= oc_code_in;
    end else if (clr_in) begin
      oc_r <= OC_NONE;
    end
  end

  assign flags_out = {ots_r, otw_r, oc_r, olon_r, oloff_r};
endmodule : dsr_chan_latch

// file: tb/dsr_host_model.sv
// host side of the open-drain sampling strobe line
// assumes the device only drives the enable; a pull-up holds the line otherwise
`timescale 1ns/1ps
module dsr_host_model (
  // device side
  input  wire logic strobe_oe_in,
  // host side
  output logic      strobe_pin_out
);
  // released line floats to the pull-up level, never to the last driven value
  assign strobe_pin_out = strobe_oe_in ? 1'b0 : 1'b1;
endmodule : dsr_host_model

// file: tb/test_dsr_readout.sv
// self-checking bench for the status readout block
// assumes the host model resolves the strobe line; inputs change at falling edges
`timescale 1ns/1ps
module test_dsr_readout;
  import dsr_pkg::*;
  logic        clk_sys_in = 0, rst_b_in = 0, addr_wr_in = 0, readout_address_persistence_in = 0, so_read_in = 0;
  logic [3:0]  readout_address_in = 0, control_input_level_in = 0, input_toggle_in = 0;
  logic [4:0]  ots_evt_in = 0, otw_evt_in = 0, oc_evt_in = 0, olon_evt_in = 0, oloff_evt_in = 0;
  logic [4:0]  output_level_bit_in = 0, offset_cancel_enable_in = 0, pwm_on_in = 0, pwm_full_in = 0;
  logic [4:0]  high_current_window_in = 0, output_fault_in = 0, offset_cancel_sense_mode_out;
  logic [14:0] oc_code_in = 0;
  logic [2:0]  feedback_select_in = 0, feedback_select_out;
  logic        fail_operation_flag_in = 0, normal_mode_in = 1, regs_cleared_evt_in = 0, undervoltage_evt_in = 0;
  logic        overvoltage_evt_in = 0, charge_pump_fault_evt_in = 0, clock_failure_evt_in = 0;
  logic        test_activation_evt_in = 0, serial_failure_evt_in = 0, limp_input_level_in = 0;
  logic        strobe_setting_low_in = 0, strobe_setting_high_in = 0, pwm_cycle_start_in = 0;
  logic        pwm_overflow_in = 0, pwm_clock_fail_in = 0, so_valid_out, feedback_enable_out;
  logic        current_feedback_gate_out, offset_polarity_out, strobe_pin, p0;
  logic        feedback_sample_strobe_drv_out, feedback_sample_strobe_oe_out;
  logic [15:0] so_word_out;
  logic [31:0] q[$];
  int          n_errors = 0, tests_run = 0, seed = 32'h33c4, k;

  dsr_readout #(.FAILSAFE_HALF(16)) dut (.*);
  dsr_host_model host (.strobe_oe_in(feedback_sample_strobe_oe_out), .strobe_pin_out(strobe_pin));

  always #12.5 clk_sys_in = ~clk_sys_in;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic stop_test;
    if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  // cycles with the strobe line pulled low over n clocks
  task automatic cnt_low(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge clk_sys_in);
      c += (strobe_pin === 1'b0);
    end
  endtask : cnt_low

  // read one word; wr=0 reads without reprogramming the address
  task automatic rd(input logic wr, input logic [3:0] a, input logic p, input logic [15:0] e,
                    input logic [15:0] m = 16'hffff);
    if (wr) begin
      {addr_wr_in, readout_address_in, readout_address_persistence_in} = {1'b1, a, p};
      @(negedge clk_sys_in);
      addr_wr_in = 0;
    end
    so_read_in = 1;
    q.push_back({m, e});
    @(negedge clk_sys_in);
    so_read_in = 0;
    @(negedge clk_sys_in);
  endtask : rd

  // one-cycle event pulse of whatever was set before the call
  task automatic pulse;
    @(negedge clk_sys_in);
    {ots_evt_in, otw_evt_in, oc_evt_in, olon_evt_in, oloff_evt_in} = '0;
    {regs_cleared_evt_in, undervoltage_evt_in, overvoltage_evt_in, charge_pump_fault_evt_in} = '0;
    {clock_failure_evt_in, test_activation_evt_in, serial_failure_evt_in} = '0;
    @(negedge clk_sys_in);
  endtask : pulse

  always @(negedge clk_sys_in) if (so_valid_out === 1'b1) begin
    if (q.size() == 0) chk("spare word", 16'h0, 16'hffff);
    else chk("so_word", q[0][15:0], so_word_out & q[0][31:16]);
    if (q.size() != 0) void'(q.pop_front());
  end

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_errors++;
    stop_test;
  end

  initial begin
    repeat (8) @(negedge clk_sys_in);
    rst_b_in = 1;
    rd(1, ADDR_ALIAS, 0, 16'h1000);
    repeat (4) begin
      {input_toggle_in, control_input_level_in, output_level_bit_in} = 13'($random(seed));
      {pwm_on_in, high_current_window_in, output_fault_in, offset_cancel_enable_in, feedback_select_in,
       strobe_setting_low_in, strobe_setting_high_in, pwm_cycle_start_in, pwm_overflow_in,
       pwm_clock_fail_in} = 28'($random(seed));
      rd(1, ADDR_IO, 1, {6'h20, |input_toggle_in, control_input_level_in, output_level_bit_in});
    end
    ots_evt_in = 5'h01;
    pulse;
    rd(1, ADDR_QUICK, 1, 16'h1201);
    rd(1, ADDR_CH1, 0, 16'h2240);
    rd(0, 4'h0, 0, 16'h1000);
    for (int c = 1; c < 7; c++) begin
      {oc_evt_in, oc_code_in} = {5'h04, 15'(7 - c) << 6};
      pulse;
      {oc_evt_in, oc_code_in} = {5'h04, 15'(c) << 6};
      pulse;
      rd(1, 4'h4, 0, 16'h4200 | 16'(c << 2));
    end
    {olon_evt_in, oloff_evt_in, otw_evt_in} = {5'h10, 5'h10, 5'h02};
    pulse;
    rd(1, ADDR_CH5, 0, 16'h6103);
    rd(1, 4'h3, 0, 16'h3020);
    {undervoltage_evt_in, test_activation_evt_in} = 2'b11;
    pulse;
    rd(1, ADDR_ID, 1, 16'h9000, 16'hf8ff);
    rd(1, ADDR_DEV, 0, 16'h7414);
    rd(1, ADDR_ID, 1, {8'h90, PART_CODE}, 16'hf8ff);
    rst_b_in = 0;
    @(negedge clk_sys_in);
    rst_b_in = 1;
    {regs_cleared_evt_in, overvoltage_evt_in, charge_pump_fault_evt_in} = '1;
    {clock_failure_evt_in, serial_failure_evt_in} = '1;
    {fail_operation_flag_in, offset_cancel_enable_in} = '1;
    pulse;
    rd(1, ADDR_QUICK, 0, 16'h1ce0);
    chk("feedback", 16'h0, {9'h0, feedback_sample_strobe_drv_out, feedback_enable_out,
                            offset_cancel_sense_mode_out});
    limp_input_level_in = 1;
    rd(1, ADDR_DEV, 0, 16'h7c0b);
    rd(0, 4'h0, 0, 16'h1800);
    fail_operation_flag_in = 0;
    {strobe_setting_high_in, strobe_setting_low_in} = STB_OFF;
    // random leftovers would pick the voltage or clock-fail square
    {feedback_select_in, pwm_clock_fail_in, pwm_on_in, high_current_window_in, output_fault_in} = '0;
    {pwm_cycle_start_in, pwm_overflow_in} = '0;
    repeat (3) @(negedge clk_sys_in);
    chk("strobe pin", 16'h1, {15'h0, strobe_pin});
    {strobe_setting_high_in, strobe_setting_low_in} = STB_VALID;
    repeat (2010) @(negedge clk_sys_in);
    chk("strobe off phase", 16'h1, {15'h0, strobe_pin});
    pwm_on_in = 5'h01;
    repeat (2) @(negedge clk_sys_in);
    chk("strobe on phase", 16'h2, {14'h0, current_feedback_gate_out, strobe_pin});
    p0 = offset_polarity_out;
    pwm_on_in = 5'h00;
    @(negedge clk_sys_in);
    chk("polarity", {15'h0, ~p0}, {15'h0, offset_polarity_out});
    pwm_on_in = 5'h01;
    repeat (1990) @(negedge clk_sys_in);
    chk("strobe blanked", 16'h1, {15'h0, strobe_pin});
    repeat (20) @(negedge clk_sys_in);
    chk("strobe after blank", 16'h0, {15'h0, strobe_pin});
    high_current_window_in = 5'h01;
    repeat (2) @(negedge clk_sys_in);
    chk("strobe in window", 16'h1, {14'h0, current_feedback_gate_out, strobe_pin});
    pwm_clock_fail_in = 1;
    cnt_low(32, k);
    chk("failsafe duty", 16'd16, 16'(k));
    {pwm_clock_fail_in, feedback_select_in} = {1'b0, SEL_TEMP};
    @(negedge clk_sys_in);
    cnt_low(1024, k);
    chk("voltage duty", 16'd512, 16'(k));
    chk("mux", 16'(SEL_TEMP), 16'(feedback_select_out));
    {feedback_select_in, pwm_full_in, high_current_window_in} = {3'h0, 5'h01, 5'h00};
    {strobe_setting_high_in, strobe_setting_low_in} = STB_NEXT;
    repeat (2) @(negedge clk_sys_in);
    chk("full duty strobe", 16'h0, {15'h0, strobe_pin});
    pwm_overflow_in = 1;
    @(negedge clk_sys_in);
    pwm_overflow_in = 0;
    cnt_low(3990, k);
    chk("overflow pulse", 16'h0, 16'(k));
    repeat (20) @(negedge clk_sys_in);
    chk("after pulse", 16'h0, {15'h0, strobe_pin});
    stop_test;
  end
endmodule : test_dsr_readout
